/* design/isfu_cfg.svh */
// constants for the in-system flash update sequencer
// assumes an apb master with 32-bit data and one word per register
// Contract
// - hold a 64K main bank and a 4K loader bank; run from main normally
// - after reset the chip program control register is read-only
// - writing 87H then 59H to the unlock register opens control writes
// - any other unlock value closes control register writes; here 87H, or 59H without a preceding 87H, leaves them open
// - update operations run only while the processor idles
// - control bit 0 set enters update mode at next wake from idle
// - bank switch clears program counter; first return goes to loader 00H
// - control bits 0, 1 and 7 all set cause a software reset to main
// - flash address is high byte register then low byte register
// - data byte holds program data and receives read data
// - control byte bit 6 selects main bank (0) or loader bank (1)
// - control byte: bit5 output enable, bit4 chip enable, bits3-0 opcode
// - erase 0010 and program 0001 with oe=1 ce=0; read 0000 with both 0
// - control register bit 5 reads running bank: 1 loader, 0 main
`ifndef ISFU_CFG_SVH
`define ISFU_CFG_SVH
// register indices; the bus byte address is four times the index
`define ISFU_IDX_CTRL_BYTE 8'hc7
`define ISFU_IDX_ADDR_HIGH 8'hc8
`define ISFU_IDX_ADDR_LOW 8'hc9
`define ISFU_IDX_DATA_BYTE 8'hca
`define ISFU_IDX_CHIP_CTRL 8'hbf
`define ISFU_IDX_UNLOCK 8'hcb
`define ISFU_IDX_STATUS 8'hcc
// byte addresses on the word-wide bus
`define ISFU_OFS_CTRL_BYTE 12'h31c
`define ISFU_OFS_ADDR_HIGH 12'h320
`define ISFU_OFS_ADDR_LOW 12'h324
`define ISFU_OFS_DATA_BYTE 12'h328
`define ISFU_OFS_CHIP_CTRL 12'h2fc
`define ISFU_OFS_UNLOCK 12'h32c
`define ISFU_OFS_STATUS 12'h330
`define ISFU_UNLOCK_FIRST 8'h87
`define ISFU_UNLOCK_SECOND 8'h59
`define ISFU_OP_ERASE 4'h2
`define ISFU_OP_PROGRAM 4'h1
`define ISFU_OP_READ 4'h0
`define ISFU_CC_ENTER 0
`define ISFU_CC_BOOT 1
`define ISFU_CC_BANK 5
`define ISFU_CC_SWRESET 7
`define ISFU_CB_BANK 6
`define ISFU_CB_OE 5
`define ISFU_CB_CE 4
`define ISFU_MAIN_BYTES 65536
`define ISFU_LOADER_BYTES 4096
`define ISFU_LOADER_PC 16'h0000
`endif

/* design/isfu_pkg.sv */
// types for the in-system flash update sequencer
// assumes isfu_cfg.svh is included by the users of these types
package isfu_pkg;
   typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_OP, ST_DONE} isfu_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } isfu_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } isfu_apb_rsp_t;
   typedef struct packed {
      isfu_state_t state;
      logic unlock_half;
      logic unlocked;
      logic [7:0] chip_ctrl;
      logic in_loader;
      logic update_mode;
      logic [7:0] ctrl_byte;
      logic [7:0] addr_high;
      logic [7:0] addr_low;
      logic [7:0] data_byte;
      logic [31:0] prdata;
      logic busy;
      logic erase_all;
      logic [16:0] erase_idx;
      logic soft_reset;
      logic pc_clear;
   } isfu_regs_t;
endpackage : isfu_pkg

/* design/isfu_top.sv */
// in-system flash update sequencer with both flash banks and apb registers
// assumes the cpu reports idle and wake events as one-cycle pulses
`timescale 1ns/1ps
`include "isfu_cfg.svh"
module isfu_top #(
   parameter int MAIN_BYTES = `ISFU_MAIN_BYTES,
   parameter int LOADER_BYTES = `ISFU_LOADER_BYTES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire isfu_pkg::isfu_apb_req_t apb_req,
   output isfu_pkg::isfu_apb_rsp_t apb_rsp,
   // processor handshake
   input wire logic cpu_idle_enter,
   input wire logic cpu_wake,
   output logic running_bank_status,
   output logic in_system_update,
   output logic cpu_pc_clear,
   output logic cpu_soft_reset,
   output logic [15:0] cpu_pc_load
);
   initial begin
      // bank indexing slices the address, so sizes must be powers of two
      if (MAIN_BYTES < 256 || MAIN_BYTES > 65536 || (MAIN_BYTES & (MAIN_BYTES - 1)) != 0 ||
          LOADER_BYTES < 256 || LOADER_BYTES > 65536 ||
          (LOADER_BYTES & (LOADER_BYTES - 1)) != 0) begin
         $error("isfu_top: bank sizes not supported");
      end
   end

   // arrays for both banks
   logic [7:0] main_program_bank [MAIN_BYTES];
   logic [7:0] loader_program_bank [LOADER_BYTES];

   isfu_pkg::isfu_regs_t r;
   isfu_pkg::isfu_regs_t next_r;
   logic [15:0] flash_addr;
   logic bus_write;
   logic bus_read;
   logic [7:0] wbyte;
   logic [7:0] read_value;
   logic do_prog;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // address formed from the two byte registers
   assign flash_addr = {r.addr_high, r.addr_low};
   assign bus_write = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign bus_read = apb_req.psel && apb_req.penable && !apb_req.pwrite;
   assign wbyte = apb_req.pwdata[7:0];
   // slave answers in the first access cycle, no wait states
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.prdata = r.prdata;
   assign apb_rsp.pslverr = 1'b0;
   assign running_bank_status = r.in_loader;
   assign in_system_update = r.update_mode;
   assign cpu_pc_clear = r.pc_clear;
   assign cpu_soft_reset = r.soft_reset;
   assign cpu_pc_load = `ISFU_LOADER_PC;
   // program strobe; bank arrays are written from their own process
   assign do_prog = (r.state == isfu_pkg::ST_OP) && !r.erase_all &&
                    (r.ctrl_byte[3:0] == `ISFU_OP_PROGRAM) &&
                    r.ctrl_byte[`ISFU_CB_OE] && !r.ctrl_byte[`ISFU_CB_CE];

   // combinational fetch from the selected bank
   always_comb begin
      if (r.ctrl_byte[`ISFU_CB_BANK]) begin
         read_value = loader_program_bank[flash_addr[$clog2(LOADER_BYTES)-1:0]];
      end else begin
         read_value = main_program_bank[flash_addr[$clog2(MAIN_BYTES)-1:0]];
      end
   end

   always_comb begin
      next_r = r;
      next_r.pc_clear = 1'b0;
      next_r.soft_reset = 1'b0;
      // register reads; unmapped reads as zero
      if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
         next_r.prdata = 32'h0000_0000;
         if (hit(apb_req.paddr, `ISFU_OFS_CTRL_BYTE)) begin
            next_r.prdata[7:0] = {1'b0, r.ctrl_byte[6:0]}; // bit 7 reserved
         end else if (hit(apb_req.paddr, `ISFU_OFS_ADDR_HIGH)) begin
            next_r.prdata[7:0] = r.addr_high;
         end else if (hit(apb_req.paddr, `ISFU_OFS_ADDR_LOW)) begin
            next_r.prdata[7:0] = r.addr_low;
         end else if (hit(apb_req.paddr, `ISFU_OFS_DATA_BYTE)) begin
            next_r.prdata[7:0] = r.data_byte;
         end else if (hit(apb_req.paddr, `ISFU_OFS_CHIP_CTRL)) begin
            next_r.prdata[7:0] = r.chip_ctrl;
            next_r.prdata[`ISFU_CC_BANK] = r.in_loader;
         end else if (hit(apb_req.paddr, `ISFU_OFS_STATUS)) begin
            next_r.prdata[2:0] = {r.busy, r.update_mode, r.unlocked};
         end
      end
      // register writes
      if (bus_write) begin
         if (hit(apb_req.paddr, `ISFU_OFS_UNLOCK)) begin
            if (wbyte == `ISFU_UNLOCK_FIRST) begin
               next_r.unlock_half = 1'b1;
            end else if (wbyte == `ISFU_UNLOCK_SECOND && r.unlock_half) begin
               next_r.unlocked = 1'b1;
               next_r.unlock_half = 1'b0;
            end else if (wbyte != `ISFU_UNLOCK_SECOND) begin
               next_r.unlocked = 1'b0;
               next_r.unlock_half = 1'b0;
            end else begin
               next_r.unlock_half = 1'b0;
            end
         end else if (hit(apb_req.paddr, `ISFU_OFS_CHIP_CTRL)) begin
            if (r.unlocked) begin
               next_r.chip_ctrl = wbyte;
               next_r.chip_ctrl[`ISFU_CC_BANK] = 1'b0;
            end
         end else if (hit(apb_req.paddr, `ISFU_OFS_CTRL_BYTE)) begin
            next_r.ctrl_byte = {1'b0, wbyte[6:0]};
         end else if (hit(apb_req.paddr, `ISFU_OFS_ADDR_HIGH)) begin
            next_r.addr_high = wbyte;
         end else if (hit(apb_req.paddr, `ISFU_OFS_ADDR_LOW)) begin
            next_r.addr_low = wbyte;
         end else if (hit(apb_req.paddr, `ISFU_OFS_DATA_BYTE)) begin
            next_r.data_byte = wbyte;
         end
      end
      // operation sequencing around the processor idle period
      unique case (r.state)
         isfu_pkg::ST_RUN: begin
            if (cpu_idle_enter) begin
               next_r.state = isfu_pkg::ST_IDLE;
            end
         end
         isfu_pkg::ST_IDLE: begin
            // work runs only while the processor idles
            next_r.state = isfu_pkg::ST_OP;
            next_r.busy = 1'b1;
            next_r.erase_all = r.update_mode && r.ctrl_byte[`ISFU_CB_OE] &&
                               !r.ctrl_byte[`ISFU_CB_CE] &&
                               (r.ctrl_byte[3:0] == `ISFU_OP_ERASE);
            next_r.erase_idx = 17'h0_0000;
         end
         isfu_pkg::ST_OP: begin
            // erase walks the bank one byte a cycle; idle must outlast it
            if (r.erase_all) begin
               next_r.erase_idx = r.erase_idx + 17'h0_0001;
               if (r.erase_idx == (r.ctrl_byte[`ISFU_CB_BANK] ?
                   17'(LOADER_BYTES - 1) : 17'(MAIN_BYTES - 1))) begin
                  next_r.state = isfu_pkg::ST_DONE;
               end
            end else begin
               // read lands in the data byte before wake
               if (r.update_mode && r.ctrl_byte[3:0] == `ISFU_OP_READ &&
                   !r.ctrl_byte[`ISFU_CB_OE] && !r.ctrl_byte[`ISFU_CB_CE]) begin
                  next_r.data_byte = read_value;
               end
               next_r.state = isfu_pkg::ST_DONE;
            end
         end
         isfu_pkg::ST_DONE: begin
            next_r.busy = 1'b0;
            next_r.erase_all = 1'b0;
            if (cpu_wake) begin
               next_r.state = isfu_pkg::ST_RUN;
               if (r.chip_ctrl[`ISFU_CC_ENTER] && r.chip_ctrl[`ISFU_CC_BOOT] &&
                   r.chip_ctrl[`ISFU_CC_SWRESET]) begin
                  // software reset back to the main bank
                  next_r.soft_reset = 1'b1;
                  next_r.in_loader = 1'b0;
                  next_r.update_mode = 1'b0;
                  next_r.chip_ctrl = 8'h00;
                  next_r.unlocked = 1'b0;
               end else if (r.chip_ctrl[`ISFU_CC_ENTER] && !r.update_mode) begin
                  next_r.update_mode = 1'b1;
                  next_r.in_loader = 1'b1;
                  next_r.pc_clear = 1'b1;
               end
            end
         end
      endcase
   end

   // banks have no reset; erased bytes read as ff
   always_ff @(posedge pclk) begin
      if (r.erase_all && r.state == isfu_pkg::ST_OP) begin
         if (r.ctrl_byte[`ISFU_CB_BANK]) begin
            loader_program_bank[r.erase_idx[$clog2(LOADER_BYTES)-1:0]] <= 8'hff;
         end else begin
            main_program_bank[r.erase_idx[$clog2(MAIN_BYTES)-1:0]] <= 8'hff;
         end
      end else if (do_prog && r.update_mode) begin
         if (r.ctrl_byte[`ISFU_CB_BANK]) begin
            loader_program_bank[flash_addr[$clog2(LOADER_BYTES)-1:0]] <= r.data_byte;
         end else begin
            main_program_bank[flash_addr[$clog2(MAIN_BYTES)-1:0]] <= r.data_byte;
         end
      end
   end

   // state register; control register locked after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{state: isfu_pkg::ST_RUN, default: '0};
      end else begin
         r <= next_r;
      end
   end
endmodule : isfu_top

/* sim/isfu_monitor.sv */
// port checker for the flash update sequencer
// assumes it is bound into isfu_top and sees only its ports
`timescale 1ns/1ps
module isfu_monitor (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // watched outputs and wake input
   input wire isfu_pkg::isfu_apb_rsp_t apb_rsp,
   input wire logic cpu_wake,
   input wire logic running_bank_status,
   input wire logic in_system_update,
   input wire logic cpu_pc_clear,
   input wire logic cpu_soft_reset,
   input wire logic [15:0] cpu_pc_load
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // steps of a bank switch and of leaving the loader
   sequence s_clear_soon;
      ##[0:1] cpu_pc_clear;
   endsequence
   sequence s_back_to_main;
      !cpu_soft_reset && !running_bank_status && !in_system_update;
   endsequence
   // zero-wait slave, never an error
   a_bus_always_ready: assert property (apb_rsp.pready && !apb_rsp.pslverr)
      else $error("apb answer not ready or flagged error");
   a_pc_load_zero: assert property (cpu_pc_load == 16'h0000)
      else $error("loader start address not zero");
   a_switch_clears_pc: assert property ($rose(in_system_update) |-> s_clear_soon)
      else $error("no pc clear on bank switch");
   a_clear_one_cycle: assert property (cpu_pc_clear |=> !cpu_pc_clear)
      else $error("pc clear longer than one cycle");
   a_clear_in_loader: assert property (cpu_pc_clear |-> running_bank_status)
      else $error("pc clear while running main bank");
   a_update_on_wake: assert property ($rose(in_system_update) |-> $past(cpu_wake) || $past(cpu_wake, 2))
      else $error("update mode entered without wake");
   a_reset_on_wake: assert property ($rose(cpu_soft_reset) |-> $past(cpu_wake) || $past(cpu_wake, 2))
      else $error("software reset without wake");
   a_reset_to_main: assert property (cpu_soft_reset |=> s_back_to_main)
      else $error("software reset did not return to main bank");
   a_loader_needs_update: assert property (running_bank_status |-> in_system_update)
      else $error("loader running outside update mode");
endmodule : isfu_monitor
bind isfu_top isfu_monitor u_mon (.pclk(pclk), .presetn(presetn), .apb_rsp(apb_rsp),
   .cpu_wake(cpu_wake), .running_bank_status(running_bank_status),
   .in_system_update(in_system_update), .cpu_pc_clear(cpu_pc_clear),
   .cpu_soft_reset(cpu_soft_reset), .cpu_pc_load(cpu_pc_load));

/* sim/isfu_top_tb.sv */
// self-checking bench for the flash update sequencer
// assumes banks shrunk by parameter so erases stay short
`timescale 1ns/1ps
`include "isfu_cfg.svh"
module isfu_top_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   isfu_pkg::isfu_apb_req_t apb_req = '0;
   isfu_pkg::isfu_apb_rsp_t apb_rsp;
   logic cpu_idle_enter = 1'b0;
   logic cpu_wake = 1'b0;
   logic bank, upd, clr, srst, seen_clr, seen_rst;
   logic [31:0] rd;
   int error_cnt = 0;
   int n_compared = 0;
   // 100 MHz clock
   always #5 pclk = ~pclk;
   isfu_top #(.MAIN_BYTES(4096), .LOADER_BYTES(1024)) dut (.pclk(pclk), .presetn(presetn),
      .apb_req(apb_req), .apb_rsp(apb_rsp), .cpu_idle_enter(cpu_idle_enter),
      .cpu_wake(cpu_wake), .running_bank_status(bank), .in_system_update(upd),
      .cpu_pc_clear(clr), .cpu_soft_reset(srst), .cpu_pc_load());
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // one apb transfer; read data kept in rd
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      apb_req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:{24'h00_0000, d}};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      rd = apb_rsp.prdata;
      apb_req <= '0;
      if (apb_rsp.pready !== 1'b1) begin
         error_cnt++;
         $display("mismatch at %0t: apb timeout", $time);
         tally_and_finish();
      end
   endtask : apb
   // idle, wait n cycles for the operation, wake, watch the pulses
   task automatic idle_cycle(input int n);
      @(posedge pclk);
      cpu_idle_enter <= 1'b1;
      @(posedge pclk);
      cpu_idle_enter <= 1'b0;
      repeat (n) @(posedge pclk);
      cpu_wake <= 1'b1;
      @(posedge pclk);
      cpu_wake <= 1'b0;
      seen_clr = 1'b0;
      seen_rst = 1'b0;
      repeat (4) begin
         #1;
         seen_clr |= clr;
         seen_rst |= srst;
         @(posedge pclk);
      end
   endtask : idle_cycle
   task automatic flash_op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d,
                           input int n);
      apb(1'b1, `ISFU_OFS_ADDR_HIGH, a[15:8]);
      apb(1'b1, `ISFU_OFS_ADDR_LOW, a[7:0]);
      apb(1'b1, `ISFU_OFS_DATA_BYTE, d);
      apb(1'b1, `ISFU_OFS_CTRL_BYTE, c);
      idle_cycle(n);
   endtask : flash_op
   task automatic flash_rd(input logic sel, input logic [15:0] a, input logic [7:0] exp);
      flash_op({1'b0, sel, 2'b00, `ISFU_OP_READ}, a, 8'h00, 6);
      apb(1'b0, `ISFU_OFS_DATA_BYTE, 8'h00);
      chk(rd[7:0], exp, "flash byte");
   endtask : flash_rd
   // locked writes ignored, stray unlock value closes
   task automatic t_lock();
      chk({7'h00, bank}, 8'h00, "bank after reset");
      apb(1'b1, `ISFU_OFS_CHIP_CTRL, 8'h01);
      apb(1'b0, `ISFU_OFS_CHIP_CTRL, 8'h00);
      chk(rd[7:0], 8'h00, "locked write");
      apb(1'b1, `ISFU_OFS_UNLOCK, `ISFU_UNLOCK_FIRST);
      apb(1'b1, `ISFU_OFS_UNLOCK, `ISFU_UNLOCK_SECOND);
      apb(1'b1, `ISFU_OFS_CHIP_CTRL, 8'h02);
      apb(1'b0, `ISFU_OFS_CHIP_CTRL, 8'h00);
      chk(rd[7:0], 8'h02, "first open write");
      apb(1'b1, `ISFU_OFS_UNLOCK, 8'h33);
      apb(1'b1, `ISFU_OFS_CHIP_CTRL, 8'h01);
      apb(1'b0, `ISFU_OFS_CHIP_CTRL, 8'h00);
      chk(rd[7:0], 8'h02, "closed write");
      apb(1'b0, 12'h0f0, 8'h00);
      chk(rd[7:0], 8'h00, "unmapped read");
   endtask : t_lock
   // bit 5 write must not stick
   task automatic t_unlock();
      apb(1'b1, `ISFU_OFS_UNLOCK, `ISFU_UNLOCK_FIRST);
      apb(1'b1, `ISFU_OFS_UNLOCK, `ISFU_UNLOCK_SECOND);
      apb(1'b1, `ISFU_OFS_CHIP_CTRL, 8'h21);
      apb(1'b0, `ISFU_OFS_CHIP_CTRL, 8'h00);
      chk(rd[7:0], 8'h01, "open write");
   endtask : t_unlock
   task automatic t_enter();
      idle_cycle(6);
      chk({6'h00, upd, seen_clr}, 8'h03, "enter update");
      apb(1'b0, `ISFU_OFS_CHIP_CTRL, 8'h00);
      chk(rd[7:0], 8'h21, "running bank");
   endtask : t_enter
   // same low byte, different high bytes and banks
   task automatic t_ops();
      flash_op(8'h22, 16'h0000, 8'h00, 4200);
      flash_op(8'h62, 16'h0000, 8'h00, 4200);
      flash_op(8'h21, 16'h0a34, 8'ha5, 6);
      flash_op(8'h21, 16'h0b34, 8'h3c, 6);
      flash_op(8'h61, 16'h0334, 8'h96, 6);
      flash_rd(1'b0, 16'h0a34, 8'ha5);
      flash_rd(1'b0, 16'h0b34, 8'h3c);
      flash_rd(1'b1, 16'h0334, 8'h96);
      flash_rd(1'b1, 16'h0234, 8'hff);
      flash_rd(1'b0, 16'h0c34, 8'hff);
   endtask : t_ops
   task automatic t_swreset();
      apb(1'b1, `ISFU_OFS_CHIP_CTRL, 8'h83);
      idle_cycle(6);
      chk({5'h00, seen_rst, bank, upd}, 8'h04, "software reset");
   endtask : t_swreset
   // reset for six cycles, then the scenarios
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_lock();
      t_unlock();
      t_enter();
      t_ops();
      t_swreset();
      tally_and_finish();
   end
endmodule : isfu_top_tb
